// ===== inc/csg_defs.vh
// Purpose: constants of the clock strap and output gating block
// Assumes: 250 MHz core clock, rstn released when supply passes threshold
// Notes: Behaviour list below
//
// Behaviour
// - PCI stop gates PCI outputs, free kept
// - CPU stop gates CPU outputs, free pair kept
// - Strap pins are inputs, then clock outputs
// - Strap pins three-stated for first 2 ms
// - Latch straps first, then enable buffers
// - Timer starts at power-on detect
// - Strap bits held until next power-up
// - Low strap latches 0, high latches 1
// - First CPU cycle may be shortened
// - Serial interface writes ctrl only; reads return strap and status
// - Config registers load defaults at power-up
// - Written spread enable is applied
// - Spread applies to CPU and PCI only
// - Config writes accepted at any time
// - Disabled outputs driven low
// - Global stop leaves only free CPU pair
// - Memory stop gates memory outputs, free kept
`ifndef CSG_DEFS_VH
`define CSG_DEFS_VH
// ***********************************************
// Timing
// ***********************************************
`define CSG_STRAP_TIME_NS   2000000
`define CSG_CLK_PERIOD_NS   4
`define CSG_STRAP_CYCLES    (`CSG_STRAP_TIME_NS / `CSG_CLK_PERIOD_NS)
// ***********************************************
// Register map
// ***********************************************
`define CSG_ADDR_CTRL       4'h0
`define CSG_ADDR_STRAP      4'h1
`define CSG_ADDR_STATUS     4'h2
`define CSG_CTRL_SPREAD_BIT 0
`define CSG_CTRL_RESET      8'h00
`define CSG_NUM_STRAPS      5
`endif

// ===== sim/csg_board_model.sv
// Purpose: board side of the strap pins and clock source
// Assumes: strap resistors weak, pin buffers win when driving
// Notes: source toggles every cycle to keep gating windows short
`timescale 1ns/10ps
module csg_board_model #(
  parameter [4:0] PULL = 5'h15
) (
  input  logic       clk,
  input  logic [4:0] strap_o,
  input  logic [4:0] strap_oe,
  output logic [4:0] strap_i,
  output logic       src
);
  // ******************
  // Pins and source
  // ******************
  logic tog_q = 1'b0;
  always @(posedge clk)
    tog_q <= ~tog_q;
  // Released pin settles to its resistor level
  assign strap_i = (strap_oe & strap_o) | (~strap_oe & PULL);
  assign src = tog_q;
endmodule

// ===== sim/csg_clock_strap_properties.sv
// Purpose: port properties of the clock strap block
// Assumes: one clock, rstn is the power-on detect
// Notes: gating windows assume sources toggling every cycle
`timescale 1ns/10ps
module csg_clock_strap_chk #(
  parameter STRAP_CYCLES = 20
) (
  input logic       clk,
  input logic       rstn,
  input logic       pci_stop_n,
  input logic       cpu_stop_n,
  input logic       mem_stop_n,
  input logic [4:0] strap_oe,
  input logic [1:0] cpu_out,
  input logic [5:0] pci_out,
  input logic [5:0] mem_out,
  input logic       spread_cpu_en,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata
);
  // ******************
  // Properties
  // ******************
  logic [19:0] cnt_q;
  always @(posedge clk or negedge rstn)
    if (!rstn)
      cnt_q <= 20'h00000;
    else
      cnt_q <= cnt_q + 20'h00001;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pins_float: assert property (cnt_q < STRAP_CYCLES |-> strap_oe == 5'h00)
    else $error("pins driven early");
  a_pins_drive: assert property (cnt_q == STRAP_CYCLES + 8 |-> strap_oe == 5'h1F)
    else $error("pins not driven");
  a_pins_hold: assert property ($past(&strap_oe) |-> &strap_oe)
    else $error("pins released");
  a_pci_gate: assert property (!pci_stop_n [*8] |-> pci_out == 6'h00)
    else $error("pci not gated");
  a_cpu_gate: assert property (!cpu_stop_n [*8] |-> cpu_out == 2'h0)
    else $error("cpu not gated");
  a_mem_gate: assert property (!mem_stop_n [*8] |-> mem_out == 6'h00)
    else $error("mem not gated");
  a_spread_set: assert property (reg_wr && reg_addr == 4'h0
    |-> ##2 spread_cpu_en == $past(reg_wdata[0], 2)) else $error("spread not set");
  a_ctrl_hidden: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == 8'h00)
    else $error("ctrl readable");
  cover property ($rose(&strap_oe));
  cover property (!cpu_stop_n [*8]);
  cover property (reg_wr && reg_addr == 4'h0);
endmodule
bind csg_clock_strap csg_clock_strap_chk #(.STRAP_CYCLES(STRAP_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n),
  .mem_stop_n(mem_stop_n), .strap_oe(strap_oe), .cpu_out(cpu_out), .pci_out(pci_out),
  .mem_out(mem_out), .spread_cpu_en(spread_cpu_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ===== sim/csg_testbench.sv
// Purpose: self-checking bench of the clock strap block
// Assumes: short strap timer of 20 cycles
// Notes: stops are driven one group at a time
`timescale 1ns/10ps
module testbench;
  localparam [4:0] PULL = 5'h15;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, src;
  logic [3:0] stop_n = 4'hF, reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, grp, act;
  logic [4:0] strap_i, strap_o, strap_oe;
  logic       cpu_t, cpu_c, pci_f, mem_f, misc, sp_cpu, sp_pci;
  logic [1:0] cpu_out, tog;
  logic [5:0] pci_out, mem_out;
  int fail_count = 0, tests_run = 0, cyc = 0;
  always #2 clk = ~clk;
  csg_board_model #(.PULL(PULL)) u_brd (.clk(clk), .strap_o(strap_o),
    .strap_oe(strap_oe), .strap_i(strap_i), .src(src));
  csg_clock_strap #(.STRAP_CYCLES(20)) u_dut (.clk(clk), .rstn(rstn),
    .pci_stop_n(stop_n[0]), .cpu_stop_n(stop_n[1]), .mem_stop_n(stop_n[2]),
    .global_stop_n(stop_n[3]), .cpu_src(src), .pci_src(src), .mem_src(src),
    .misc_src(src), .strap_i(strap_i), .strap_o(strap_o), .strap_oe(strap_oe),
    .cpu_free_true_out(cpu_t), .cpu_free_comp_out(cpu_c), .cpu_out(cpu_out),
    .pci_free_out(pci_f), .pci_out(pci_out), .mem_free_out(mem_f), .mem_out(mem_out),
    .misc_out(misc), .spread_cpu_en(sp_cpu), .spread_pci_en(sp_pci), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 8'h00);
    check({6'h00, sp_cpu, sp_pci}, 8'h00);
    check({3'h0, strap_oe}, 8'h00);
    $display("test defaults done");
    repeat (40) @(negedge clk);
    check({3'h0, strap_oe}, 8'h1F);
    rd(4'h1, {3'h0, PULL});
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h01);
    repeat (2) @(negedge clk);
    check({6'h00, sp_cpu, sp_pci}, 8'h03);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h00);
    repeat (2) @(negedge clk);
    check({6'h00, sp_cpu, sp_pci}, 8'h00);
    act = 8'h00;
    repeat (16)
    begin
      @(negedge clk);
      act = act | {pci_f, |pci_out, |cpu_out, mem_f, |mem_out, misc, |strap_o, cpu_c};
    end
    check(act, 8'hFF);
    check({7'h00, cpu_c}, {7'h00, ~cpu_t});
    $display("test straps and spread done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      stop_n <= ~(4'h1 << i);
      tog = 2'h0;
      repeat (16)
      begin
        @(negedge clk);
        tog = tog | {cpu_t, ~cpu_t};
      end
      grp = (i == 0) ? {2'h0, pci_out} : (i == 1) ? {6'h00, cpu_out}
          : (i == 2) ? {2'h0, mem_out} : {pci_f, |pci_out, |cpu_out, mem_f, |mem_out, misc};
      check(grp, 8'h00);
      check({6'h00, tog}, 8'h03);
      @(posedge clk);
      stop_n <= 4'hF;
      repeat (16) @(posedge clk);
    end
    rd(4'h1, {3'h0, PULL});
    $display("test stops done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({3'h0, strap_oe}, 8'h00);
    repeat (40) @(negedge clk);
    check({3'h0, strap_oe}, 8'h1F);
    rd(4'h1, {3'h0, PULL});
    $display("test power cycle done");
    complete_run;
  end
endmodule

// ===== src/csg_clock_strap.v
// Purpose: strap sampling and stop-input gating of the clock outputs
// Assumes: clock sources arrive as inputs; config bytes arrive decoded
// Notes: one clock domain, no interrupts
`timescale 1ns/10ps
`include "csg_defs.vh"
module csg_clock_strap #(
  parameter STRAP_CYCLES = `CSG_STRAP_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        pci_stop_n,
  input  wire        cpu_stop_n,
  input  wire        mem_stop_n,
  input  wire        global_stop_n,
  input  wire        cpu_src,
  input  wire        pci_src,
  input  wire        mem_src,
  input  wire        misc_src,
  input  wire [4:0]  strap_i,
  output reg  [4:0]  strap_o,
  output reg  [4:0]  strap_oe,
  output reg         cpu_free_true_out,
  output reg         cpu_free_comp_out,
  output reg  [1:0]  cpu_out,
  output reg         pci_free_out,
  output reg  [5:0]  pci_out,
  output reg         mem_free_out,
  output reg  [5:0]  mem_out,
  output reg         misc_out,
  output reg         spread_cpu_en,
  output reg         spread_pci_en,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata
);
  // ***********************************************
  // Synchronisers
  // ***********************************************
  reg  [3:0]  stop_s1_q;
  reg  [3:0]  stop_s2_q;
  reg  [4:0]  strap_s1_q;
  reg  [4:0]  strap_s2_q;
  reg  [3:0]  src_s1_q;
  reg  [3:0]  src_s2_q;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stop_s1_q  <= 4'hF;
      stop_s2_q  <= 4'hF;
      strap_s1_q <= 5'h00;
      strap_s2_q <= 5'h00;
      src_s1_q   <= 4'h0;
      src_s2_q   <= 4'h0;
    end
    else
    begin
      stop_s1_q  <= {global_stop_n, mem_stop_n, cpu_stop_n, pci_stop_n};
      stop_s2_q  <= stop_s1_q;
      strap_s1_q <= strap_i;
      strap_s2_q <= strap_s1_q;
      src_s1_q   <= {misc_src, mem_src, pci_src, cpu_src};
      src_s2_q   <= src_s1_q;
    end
  end

  // ***********************************************
  // Strap timer and latch
  // ***********************************************
  // Reset release stands for the power-on detector
  localparam ST_WAIT = 2'h0;
  localparam ST_LTCH = 2'h1;
  localparam ST_RUN  = 2'h2;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [19:0] timer_q;
  reg  [4:0]  strap_q;
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: if (timer_q == STRAP_CYCLES[19:0] - 20'h00001) state_d = ST_LTCH;
      ST_LTCH: state_d = ST_RUN;
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_WAIT;
    endcase
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_WAIT;
      timer_q <= 20'h00000;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_WAIT)
        timer_q <= timer_q + 20'h00001;
    end
  end

  // Per-pin latch, written once; only a new power-up clears it
  genvar gi;
  generate
    for (gi = 0; gi < `CSG_NUM_STRAPS; gi = gi + 1)
    begin : g_strap
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          strap_q[gi] <= 1'b0;
        else if (state_q == ST_LTCH)
          strap_q[gi] <= strap_s2_q[gi];
      end
    end
  endgenerate

  wire run = (state_q == ST_RUN);

  // ***********************************************
  // Config register, write-only from the link
  // ***********************************************
  reg  [7:0]  ctrl_q;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= `CSG_CTRL_RESET;
    else if (reg_wr && reg_addr == `CSG_ADDR_CTRL)
      ctrl_q <= reg_wdata;
  end
  // Readback is local status only; ctrl never returns to the link
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == `CSG_ADDR_STRAP)
      reg_rdata <= {3'h0, strap_q};
    else if (reg_rd && reg_addr == `CSG_ADDR_STATUS)
      reg_rdata <= {6'h00, state_q};
    else
      reg_rdata <= 8'h00;
  end
  // ***********************************************
  // Gates, updated only while source low
  // ***********************************************
  reg         g_pci_q;
  reg         g_cpu_q;
  reg         g_mem_q;
  reg         g_misc_q;
  reg         g_pfree_q;
  reg         g_mfree_q;
  wire        gstop = ~stop_s2_q[3];
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      g_pci_q   <= 1'b0;
      g_cpu_q   <= 1'b0;
      g_mem_q   <= 1'b0;
      g_misc_q  <= 1'b0;
      g_pfree_q <= 1'b0;
      g_mfree_q <= 1'b0;
    end
    else
    begin
      if (!src_s2_q[1])
        g_pci_q <= run & stop_s2_q[0] & ~gstop;
      if (!src_s2_q[1])
        g_pfree_q <= run & ~gstop;
      if (!src_s2_q[0])
        g_cpu_q <= run & stop_s2_q[1] & ~gstop;
      if (!src_s2_q[2])
        g_mem_q <= run & stop_s2_q[2] & ~gstop;
      if (!src_s2_q[2])
        g_mfree_q <= run & ~gstop;
      if (!src_s2_q[3])
        g_misc_q <= run & ~gstop;
    end
  end
  // ***********************************************
  // Output drive
  // ***********************************************
  // Free CPU pair opens at once; a short first cycle is tolerated
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_free_true_out <= 1'b0;
      cpu_free_comp_out <= 1'b0;
      cpu_out           <= 2'h0;
      pci_free_out      <= 1'b0;
      pci_out           <= 6'h00;
      mem_free_out      <= 1'b0;
      mem_out           <= 6'h00;
      misc_out          <= 1'b0;
      strap_o           <= 5'h00;
      strap_oe          <= 5'h00;
      spread_cpu_en     <= 1'b0;
      spread_pci_en     <= 1'b0;
    end
    else
    begin
      cpu_free_true_out <= run & src_s2_q[0];
      cpu_free_comp_out <= run & ~src_s2_q[0];
      cpu_out           <= {2{g_cpu_q & src_s2_q[0]}};
      pci_free_out      <= g_pfree_q & src_s2_q[1];
      pci_out           <= {6{g_pci_q & src_s2_q[1]}};
      mem_free_out      <= g_mfree_q & src_s2_q[2];
      mem_out           <= {6{g_mem_q & src_s2_q[2]}};
      misc_out          <= g_misc_q & src_s2_q[3];
      strap_o           <= {g_misc_q & src_s2_q[3], g_misc_q & src_s2_q[3],
                            g_misc_q & src_s2_q[3], g_pfree_q & src_s2_q[1],
                            g_pci_q & src_s2_q[1]};
      strap_oe          <= {5{run}};
      spread_cpu_en     <= ctrl_q[`CSG_CTRL_SPREAD_BIT];
      spread_pci_en     <= ctrl_q[`CSG_CTRL_SPREAD_BIT];
    end
  end
endmodule
